/* hw/fsr_pkg.sv */
/*
  Package for the loop status and ratio block: widths, counts, carriers.
  Assumes a single 50 MHz system clock and a slow 32 kHz tick input.
*/
`default_nettype none
package fsr_pkg;
  localparam int unsigned NUM_LOOPS        = 2;
  localparam int unsigned SYS_CLK_HZ       = 50_000_000;
  localparam int unsigned DEB_STABLE_TICKS = 4;
  localparam int unsigned DEB_CNT_W        = 3;
  localparam int unsigned REFDIV_W         = 2;
  localparam int unsigned OUTDIV_W         = 3;
  localparam int unsigned RATIO_W          = 4;
  localparam int unsigned INTMUL_W         = 10;
  localparam int unsigned FRAC_W           = 16;
  localparam int unsigned FREF_MAX_HZ      = 13_500_000;
  localparam int unsigned VCO_DIVISOR      = 3;
  localparam logic [REFDIV_W-1:0] REFDIV_BY1 = 2'h0;
  localparam logic [RATIO_W-1:0]  RATIO_BY1  = 4'h0;
  localparam logic [OUTDIV_W-1:0] OUTDIV_BY2 = 3'h2;

  typedef struct packed {
    logic clk_good;
    logic locked;
  } fsr_status_s;

  typedef struct packed {
    logic [REFDIV_W-1:0] ref_predivider_sel;
    logic [OUTDIV_W-1:0] vco_output_divider;
    logic [RATIO_W-1:0]  loop_ratio_sel;
    logic [INTMUL_W-1:0] integer_multiplier;
    logic [FRAC_W-1:0]   fraction_numerator;
    logic [FRAC_W-1:0]   fraction_denominator;
  } fsr_ratio_cfg_s;
endpackage
`default_nettype wire

/* hw/fsr_debounce.sv */
/*
  One-bit debounce filter: passes a change only after it stays stable for
  a fixed number of filter ticks. Assumes the input is synchronous.
*/
`default_nettype none
module fsr_debounce (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // filter tick and data
  input  wire logic tick,
  input  wire logic raw_in,
  output logic      filt_ff
);
  logic [fsr_pkg::DEB_CNT_W-1:0] cnt_ff;
  logic [fsr_pkg::DEB_CNT_W-1:0] nxt_cnt;
  logic                          nxt_filt;

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_filt = filt_ff;
    if (raw_in == filt_ff) begin
      nxt_cnt = '0;
    end else if (tick) begin
      if (cnt_ff == fsr_pkg::DEB_CNT_W'(fsr_pkg::DEB_STABLE_TICKS - 1)) begin
        nxt_filt = raw_in;
        nxt_cnt  = '0;
      end else begin
        nxt_cnt = cnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff  <= '0;
      filt_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      filt_ff <= nxt_filt;
    end
  end
endmodule
`default_nettype wire

/* hw/fsr_top.sv */
/*
  Loop status reporting and ratio configuration checking for each loop:
  debounced interrupt levels with one-cycle rise events, undebounced pin
  copies of the status, a pin route for the loop-derived clock, and flags
  for ratio settings whose N.K would come out as a whole number.
  Assumes analog loop status arrives synchronous to clk_sys, a 32 kHz
  tick pulse input that is high for one cycle per slow period, two level
  inputs that say which filter clock runs, and an interrupt controller
  and pin mux outside that take the registered outputs as they stand.
*/
`default_nettype none
// Operation
// (R1) each loop reports clock-good once started and delivering output clock
// (R2) each loop reports whether frequency lock is currently achieved
// (R3) clock-good and lock both feed the interrupt event outputs
// (R4) interrupt paths debounced; assert only while 32 kHz or system clock runs
// (R5) pin status path is undebounced and needs no clock; here the pin copies are registered on clk_sys
// (R6) loop-derived clock can be routed to a pin when selected
// (R7) software picks reference divider so divided reference stays at most 13.5 MHz
// (R8) software picks output divider; oscillator equals output times divider
// (R9) software picks ratio; N.K equals oscillator over ratio times 3 times reference
// (R10) software confirms N.K non-integer and reference below limit
// (R11) software loads integer multiplier with integer part of N.K
// (R12) common divisor is gcd of ratio times reference and oscillator over 3
// (R13) numerator and denominator follow oscillator, N, ratio, reference, divisor
// (R14) output equals source over divider, times 3, N.K, ratio, over output divider
// (R15) for 147.456 MHz system clock target 294.912 MHz oscillator
// (R16) with synchroniser, main and synchroniser loops configured separately
// (R17) interrupt debounce needs a fixed count of stable filter ticks
module fsr_top (
  // clock and reset
  input  wire logic                           clk_sys,
  input  wire logic                           reset_n,
  // filter clock sources
  input  wire logic                           tick_32k,
  input  wire logic                           system_core_clock_enabled,
  input  wire logic                           slow_clk_enabled,
  // raw loop status from the analog loops
  input  wire fsr_pkg::fsr_status_s           loop_status_raw [fsr_pkg::NUM_LOOPS],
  input  wire logic [fsr_pkg::NUM_LOOPS-1:0]  loop_clk_in,
  // ratio settings, one set per loop, main and synchroniser
  input  wire fsr_pkg::fsr_ratio_cfg_s        main_cfg [fsr_pkg::NUM_LOOPS],
  input  wire fsr_pkg::fsr_ratio_cfg_s        sync_cfg [fsr_pkg::NUM_LOOPS],
  input  wire logic [fsr_pkg::NUM_LOOPS-1:0]  sync_enable,
  // pin function selects
  input  wire logic [fsr_pkg::NUM_LOOPS-1:0]  pin_clk_sel,
  // interrupt controller side
  output logic [fsr_pkg::NUM_LOOPS-1:0]       irq_clk_good_ff,
  output logic [fsr_pkg::NUM_LOOPS-1:0]       irq_locked_ff,
  output logic [fsr_pkg::NUM_LOOPS-1:0]       irq_clk_good_evt_ff,
  output logic [fsr_pkg::NUM_LOOPS-1:0]       irq_locked_evt_ff,
  // pin multiplexer side
  output logic [fsr_pkg::NUM_LOOPS-1:0]       pin_clk_good_ff,
  output logic [fsr_pkg::NUM_LOOPS-1:0]       pin_locked_ff,
  output logic [fsr_pkg::NUM_LOOPS-1:0]       pin_clk_out_ff,
  // configuration sanity
  output logic [fsr_pkg::NUM_LOOPS-1:0]       cfg_integer_nk_ff,
  output logic [fsr_pkg::NUM_LOOPS-1:0]       cfg_sync_integer_nk_ff
);
  localparam int unsigned NL = fsr_pkg::NUM_LOOPS;

  // filter clocking
  logic               filt_tick;
  logic               clocks_run;
  // raw status split per kind
  logic [NL-1:0]      raw_good;
  logic [NL-1:0]      raw_lock;
  // debounced status, one filter output per bit
  wire logic [NL-1:0] deb_good;
  wire logic [NL-1:0] deb_lock;
  // next values of the output registers
  logic [NL-1:0]      nxt_irq_good;
  logic [NL-1:0]      nxt_irq_lock;
  logic [NL-1:0]      nxt_good_evt;
  logic [NL-1:0]      nxt_lock_evt;
  logic [NL-1:0]      nxt_pin_good;
  logic [NL-1:0]      nxt_pin_lock;
  logic [NL-1:0]      nxt_pin_clk;
  logic [NL-1:0]      nxt_int_nk;
  logic [NL-1:0]      nxt_sync_int_nk;

  // numerator zero: the fraction K vanishes and N.K is whole,
  // which software must avoid
  function automatic logic frac_is_whole(input fsr_pkg::fsr_ratio_cfg_s cfg);
    return (cfg.fraction_numerator == '0);
  endfunction

  // filter advances on slow tick, or every cycle when system clock runs
  assign clocks_run = system_core_clock_enabled | slow_clk_enabled;
  assign filt_tick  = system_core_clock_enabled | (slow_clk_enabled & tick_32k); // [R4]

  always_comb begin
    for (int i = 0; i < NL; i++) begin
      raw_good[i] = loop_status_raw[i].clk_good; // [R1]
      raw_lock[i] = loop_status_raw[i].locked;   // [R2]
    end
  end

  // clock-good filters
  for (genvar i = 0; i < NL; i++) begin : g_deb_good
    fsr_debounce u_deb_good (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .tick    (filt_tick),
      .raw_in  (raw_good[i]),
      .filt_ff (deb_good[i])
    ); // [R17]
  end

  // lock filters
  for (genvar i = 0; i < NL; i++) begin : g_deb_lock
    fsr_debounce u_deb_lock (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .tick    (filt_tick),
      .raw_in  (raw_lock[i]),
      .filt_ff (deb_lock[i])
    ); // [R17]
  end

  // interrupt levels: filtered status, held low while no filter clock runs
  always_comb begin
    for (int i = 0; i < NL; i++) begin
      nxt_irq_good[i] = deb_good[i] & clocks_run; // [R1] [R3] [R4]
      nxt_irq_lock[i] = deb_lock[i] & clocks_run; // [R2] [R3] [R4]
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_clk_good_ff <= '0;
      irq_locked_ff   <= '0;
    end else begin
      irq_clk_good_ff <= nxt_irq_good;
      irq_locked_ff   <= nxt_irq_lock;
    end
  end

  // one-cycle event on each rise of a gated level; a clock restart with
  // status already good therefore raises a fresh event
  always_comb begin
    for (int i = 0; i < NL; i++) begin
      nxt_good_evt[i] = nxt_irq_good[i] & ~irq_clk_good_ff[i]; // [R3]
      nxt_lock_evt[i] = nxt_irq_lock[i] & ~irq_locked_ff[i];   // [R3]
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_clk_good_evt_ff <= '0;
      irq_locked_evt_ff   <= '0;
    end else begin
      irq_clk_good_evt_ff <= nxt_good_evt;
      irq_locked_evt_ff   <= nxt_lock_evt;
    end
  end

  // pin copies: raw status, no filter and no clock gating
  always_comb begin
    for (int i = 0; i < NL; i++) begin
      nxt_pin_good[i] = raw_good[i]; // [R1] [R5]
      nxt_pin_lock[i] = raw_lock[i]; // [R2] [R5]
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_clk_good_ff <= '0;
      pin_locked_ff   <= '0;
    end else begin
      pin_clk_good_ff <= nxt_pin_good;
      pin_locked_ff   <= nxt_pin_lock;
    end
  end

  // loop-derived clock to the pin only where selected, not divided again
  always_comb begin
    for (int i = 0; i < NL; i++) begin
      nxt_pin_clk[i] = pin_clk_sel[i] & loop_clk_in[i]; // [R6] [R14]
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_clk_out_ff <= '0;
    end else begin
      pin_clk_out_ff <= nxt_pin_clk;
    end
  end

  // main loop settings: flag a whole N.K,
  // the loop is only meant to run with a fraction
  always_comb begin
    for (int i = 0; i < NL; i++) begin
      nxt_int_nk[i] = frac_is_whole(main_cfg[i]); // [R10] [R13]
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cfg_integer_nk_ff <= '0;
    end else begin
      cfg_integer_nk_ff <= nxt_int_nk;
    end
  end

  // synchroniser settings only count while that loop uses them
  always_comb begin
    for (int i = 0; i < NL; i++) begin
      nxt_sync_int_nk[i] = sync_enable[i] & frac_is_whole(sync_cfg[i]); // [R13] [R16]
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cfg_sync_integer_nk_ff <= '0;
    end else begin
      cfg_sync_integer_nk_ff <= nxt_sync_int_nk;
    end
  end
endmodule
`default_nettype wire

/* testbench/fsr_top_assertions.sv */
/* Checker on fsr_top status outputs.
   Assumes it is bound to fsr_top, single clock domain. */
`default_nettype none
module fsr_chk (
  // clock and inputs
  input wire logic                          clk_sys,
  input wire logic                          reset_n,
  input wire logic                          system_core_clock_enabled,
  input wire logic                          slow_clk_enabled,
  input wire fsr_pkg::fsr_status_s          loop_status_raw [fsr_pkg::NUM_LOOPS],
  // status outputs
  input wire logic [fsr_pkg::NUM_LOOPS-1:0] irq_clk_good_ff,
  input wire logic [fsr_pkg::NUM_LOOPS-1:0] irq_locked_ff,
  input wire logic [fsr_pkg::NUM_LOOPS-1:0] irq_clk_good_evt_ff,
  input wire logic [fsr_pkg::NUM_LOOPS-1:0] irq_locked_evt_ff,
  input wire logic [fsr_pkg::NUM_LOOPS-1:0] pin_clk_good_ff
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_pin; pin_clk_good_ff[0] == $past(loop_status_raw[0].clk_good); endproperty
  a_pin: assert property (p_pin) else $error("pin status lag");
  property p_gate; (!system_core_clock_enabled && !slow_clk_enabled) [*2] |-> !irq_clk_good_ff; endproperty
  a_gate: assert property (p_gate) else $error("irq without clock");
  property p_gatel; (!system_core_clock_enabled && !slow_clk_enabled) [*2] |-> !irq_locked_ff; endproperty
  a_gatel: assert property (p_gatel) else $error("lock irq without clock");
  property p_evt; irq_clk_good_evt_ff == (irq_clk_good_ff & ~$past(irq_clk_good_ff)); endproperty
  a_evt: assert property (p_evt) else $error("clock good event");
  property p_evtl; irq_locked_evt_ff == (irq_locked_ff & ~$past(irq_locked_ff)); endproperty
  a_evtl: assert property (p_evtl) else $error("lock event");
  property p_rise;
    system_core_clock_enabled [*6] ##0 $rose(irq_clk_good_ff[0]) |-> $past(loop_status_raw[0].clk_good, 2)
      && $past(loop_status_raw[0].clk_good, 3) && $past(loop_status_raw[0].clk_good, 4);
  endproperty
  a_rise: assert property (p_rise) else $error("irq before filter");
  property p_hold; (system_core_clock_enabled && loop_status_raw[0].clk_good) [*7] |-> irq_clk_good_ff[0];
  endproperty
  a_hold: assert property (p_hold) else $error("clock good irq late");
  property p_fall; (system_core_clock_enabled && !loop_status_raw[1].locked) [*7] |-> !irq_locked_ff[1];
  endproperty
  a_fall: assert property (p_fall) else $error("lock irq stuck");
  c_rise: cover property ($rose(irq_clk_good_ff[0]));
  c_slow: cover property (!system_core_clock_enabled && slow_clk_enabled && $fell(irq_locked_ff[0]));
  c_lock: cover property (irq_locked_evt_ff[0]);
endmodule
bind fsr_top fsr_chk i_chk (.*);
`default_nettype wire

/* testbench/fsr_partner.sv */
/* Reference side model: 32 kHz tick and loop clocks.
   Assumes launch on the falling edge of clk_sys. */
`default_nettype none
module fsr_partner #(parameter int TICK = 16) (
  // clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         reset_n,
  // clock sources
  output var logic                          tick_32k,
  output var logic [fsr_pkg::NUM_LOOPS-1:0] loop_clk_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int div;
  always @(negedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div <= 0;
      tick_32k <= 1'h0;
      loop_clk_in <= '0;
    end else begin
      div <= (div == TICK - 1) ? 0 : div + 1;
      tick_32k <= (div == TICK - 1);
      loop_clk_in <= {loop_clk_in[0], ~loop_clk_in[1]};
    end
  end
endmodule
`default_nettype wire

/* testbench/tb.sv */
/* Self-checking bench for fsr_top.
   Assumes fsr_partner and the bound checker. */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [fsr_pkg::NUM_LOOPS-1:0] fsr_lv_t;
  localparam int TICK = 16;
  localparam fsr_pkg::fsr_ratio_cfg_s CFG12 = '{2'h0, 3'h2, 4'h0, 10'h008, 16'h0018, 16'h007D};
  logic                    clk_sys, reset_n, tick_32k, system_core_clock_enabled, slow_clk_enabled;
  fsr_lv_t                 loop_clk_in, sync_enable, pin_clk_sel, irq_clk_good_ff, irq_locked_ff;
  fsr_lv_t                 irq_clk_good_evt_ff, irq_locked_evt_ff, pin_clk_good_ff, pin_locked_ff;
  fsr_lv_t                 pin_clk_out_ff, cfg_integer_nk_ff, cfg_sync_integer_nk_ff;
  fsr_lv_t                 clk_seen;
  fsr_pkg::fsr_status_s    loop_status_raw [fsr_pkg::NUM_LOOPS];
  fsr_pkg::fsr_ratio_cfg_s main_cfg [fsr_pkg::NUM_LOOPS], sync_cfg [fsr_pkg::NUM_LOOPS];
  int                      error_cnt = 0, comparisons = 0;
  fsr_top i_dut (.*);
  fsr_partner #(.TICK(TICK)) i_src (.clk_sys(clk_sys), .reset_n(reset_n),
    .tick_32k(tick_32k), .loop_clk_in(loop_clk_in));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic summarize();
    if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (1000) @(posedge clk_sys);
    error_cnt++;
    summarize();
  end
  initial begin
    {reset_n, system_core_clock_enabled, slow_clk_enabled, sync_enable, pin_clk_sel} = '0;
    loop_status_raw = '{default: '0};
    main_cfg = '{2{CFG12}};
    sync_cfg = '{2{CFG12}};
    repeat (8) @(posedge clk_sys);
    cyc(1);
    reset_n = 1'h1;
    cyc(2);
    chk("rst", {irq_clk_good_ff, pin_clk_good_ff, cfg_integer_nk_ff}, 6'h00);
    system_core_clock_enabled = 1'h1;
    loop_status_raw[0] = 2'h3;
    cyc(1);
    chk("pin", {pin_clk_good_ff[0], pin_locked_ff[0], irq_clk_good_ff[0]}, 3'h6);
    cyc(3);
    chk("pre", {irq_clk_good_ff[0], irq_locked_ff[0]}, 2'h0);
    cyc(1);
    chk("evt", {irq_clk_good_evt_ff[0], irq_locked_evt_ff[0]}, 2'h3);
    cyc(1);
    chk("evt_end", {irq_clk_good_evt_ff, irq_locked_evt_ff}, 4'h0);
    cyc(1);
    chk("irq", {irq_clk_good_ff[0], irq_locked_ff[0]}, 2'h3);
    loop_status_raw[1].locked = 1'h1;
    cyc(2);
    loop_status_raw[1].locked = 1'h0;
    cyc(8);
    chk("glitch", {irq_locked_ff[1], pin_locked_ff[1]}, 2'h0);
    system_core_clock_enabled = 1'h0;
    loop_status_raw[0].locked = 1'h0;
    loop_status_raw[1].clk_good = 1'h1;
    cyc(2);
    chk("off", {irq_clk_good_ff[0], pin_clk_good_ff[1], pin_locked_ff[0]}, 3'h2);
    slow_clk_enabled = 1'h1;
    cyc(2 + 2 * TICK);
    chk("frozen", irq_locked_ff[0], 1'h1);
    cyc(4 * TICK);
    chk("slow", {irq_locked_ff[0], irq_clk_good_ff[1]}, 2'h1);
    pin_clk_sel = 2'h1;
    repeat (4) begin
      @(posedge clk_sys);
      clk_seen = loop_clk_in;
      cyc(1);
      chk("clkout", pin_clk_out_ff, clk_seen & 2'h1);
    end
    main_cfg[0].fraction_numerator = '0;
    sync_cfg[1].fraction_numerator = '0;
    cyc(2);
    chk("cfg", {cfg_integer_nk_ff, cfg_sync_integer_nk_ff}, 4'h4);
    sync_enable = 2'h2;
    cyc(2);
    chk("sync", cfg_sync_integer_nk_ff, 2'h2);
    summarize();
  end
endmodule
`default_nettype wire
